/* verilog/ptmc_pkg.sv */
// package: register map, field layout and types of the pattern trigger/mode control
package ptmc_pkg;

  localparam int PTMC_NUM_GRP = 4;
  localparam int PTMC_NUM_PIN_GRP = 3;
  localparam int PTMC_NUM_CH = 4;
  localparam int PTMC_SEL_W = 2;
  localparam int PTMC_GRP_W = 4;

  localparam logic [7:0] PTMC_OFS_TRIG_SEL = 8'h00;
  localparam logic [7:0] PTMC_OFS_MODE = 8'h04;
  localparam logic [7:0] PTMC_OFS_STATUS = 8'h08;

  localparam logic [7:0] PTMC_TRIG_SEL_RST = 8'hff;
  localparam logic [7:0] PTMC_MODE_RST = 8'hf0;
  localparam logic [7:0] PTMC_MODE_RO_MASK = 8'hf0;
  localparam logic [7:0] PTMC_MODE_RW_MASK = 8'h0f;
  localparam int PTMC_MODE_SPARE_BIT = 3;

  localparam logic [1:0] PTMC_RESP_OKAY = 2'b00;
  localparam logic [1:0] PTMC_RESP_SLVERR = 2'b10;

  // one timer channel's event pulses
  typedef struct packed {
    logic match_a;
    logic match_b;
  } ptmc_evt_t;

  // what a group does to its port latch in one cycle
  typedef struct packed {
    logic [PTMC_GRP_W-1:0] load;
    logic [PTMC_GRP_W-1:0] data;
  } ptmc_load_t;

endpackage

/* verilog/ptmc_group.sv */
// one output group: trigger selection and normal / non-overlap load decision
`timescale 1ns/1ps
module ptmc_group
  import ptmc_pkg::*;
#(
  parameter int NCH = PTMC_NUM_CH,
  parameter int GW = PTMC_GRP_W
) (
  input wire logic [PTMC_SEL_W-1:0] sel,
  input wire logic nonoverlap,
  input wire ptmc_evt_t [NCH-1:0] evt,
  input wire logic [GW-1:0] next_val,
  input wire logic [GW-1:0] enable,
  output ptmc_load_t load
);

  ptmc_evt_t chosen;

  always_comb begin
    chosen = evt[sel];
    load.data = next_val;
    if (chosen.match_a) begin
      load.load = enable;
    end else if (nonoverlap && chosen.match_b) begin
      load.load = enable & ~next_val;
    end else begin
      load.load = '0;
    end
  end

endmodule

/* verilog/ptmc_top.sv */
// top: axi4-lite register bank for trigger select and overlap mode, plus group strobes
//
// The AXI4-Lite slave port and the register offsets were decided locally.
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
// Behaviour
// - trigger select resets to all ones, also in hardware standby; kept in software standby
// - bits 7:6 select group 3 trigger; group 3 has no pins
// - bits 5:4 select the channel loading group 2, pins 11..8
// - bits 3:2 select the channel loading group 1, pins 7..4
// - bits 1:0 select the channel loading group 0, pins 3..0
// - field values 0..3 pick timer channels 0..3; reset value is 3
// - mode register resets to f0, also in hardware standby; kept in software standby
// - mode bits 7..4 ignore writes and read as one
// - mode bit 3 is a plain storage bit
// - mode bits 2..0 pick normal or non-overlap for groups 2..0
// - normal mode: group loads only at compare match A
// - non-overlap mode: group loads at both compare match A and B
// - non-overlap, match A: every enabled next-value bit is copied
// - non-overlap, match B: only enabled next-value bits equal zero are copied
// - input capture on register A acts in place of match A
module ptmc_top
  import ptmc_pkg::*;
#(
  parameter int NCH = PTMC_NUM_CH
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic hw_standby,
  input wire logic [NCH-1:0] cmp_match_a,
  input wire logic [NCH-1:0] cmp_match_b,
  input wire logic [NCH-1:0] capture_a,
  input wire logic [NCH-1:0] gra_is_capture,
  input wire logic [PTMC_NUM_PIN_GRP*PTMC_GRP_W-1:0] next_value_latch,
  input wire logic [PTMC_NUM_PIN_GRP*PTMC_GRP_W-1:0] next_enable,
  output logic [PTMC_NUM_PIN_GRP*PTMC_GRP_W-1:0] port_latch_load,
  output logic [PTMC_NUM_PIN_GRP*PTMC_GRP_W-1:0] port_latch_data,
  output logic [PTMC_SEL_W-1:0] grp3_trigger_sel,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  logic [7:0] group_trigger_select_r;
  logic [7:0] group_overlap_mode_r;
  logic [NCH-1:0] fired_a_r;
  logic [NCH-1:0] fired_b_r;
  logic rst_all;
  ptmc_evt_t [NCH-1:0] evt;
  ptmc_load_t [PTMC_NUM_PIN_GRP-1:0] grp_load;

  // hardware standby clears like reset; software standby is not seen here at all
  assign rst_all = !aresetn || hw_standby;

  //////////////////////////////////////////////////////////////////////////////
  // axi4-lite write channel: address and data taken in either order
  logic aw_held_r;
  logic w_held_r;
  logic [7:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic do_write;

  assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
  assign s_axi_wready = !w_held_r && !s_axi_bvalid;
  assign do_write = aw_held_r && w_held_r && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      aw_addr_r <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_r <= 1'b1;
      aw_addr_r <= s_axi_awaddr[7:0];
    end else if (do_write) begin
      aw_held_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_r <= 1'b0;
      w_data_r <= '0;
      w_strb_r <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_r <= 1'b1;
      w_data_r <= s_axi_wdata;
      w_strb_r <= s_axi_wstrb;
    end else if (do_write) begin
      w_held_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= PTMC_RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (aw_addr_r == PTMC_OFS_TRIG_SEL || aw_addr_r == PTMC_OFS_MODE ||
                      aw_addr_r == PTMC_OFS_STATUS) ? PTMC_RESP_OKAY : PTMC_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // control registers
  always_ff @(posedge aclk) begin
    if (rst_all) begin
      group_trigger_select_r <= PTMC_TRIG_SEL_RST;
    end else if (do_write && aw_addr_r == PTMC_OFS_TRIG_SEL && w_strb_r[0]) begin
      group_trigger_select_r <= w_data_r[7:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (rst_all) begin
      group_overlap_mode_r <= PTMC_MODE_RST;
    end else if (do_write && aw_addr_r == PTMC_OFS_MODE && w_strb_r[0]) begin
      // upper nibble is constant ones, bit 3 is spare storage
      group_overlap_mode_r <= PTMC_MODE_RO_MASK | (w_data_r[7:0] & PTMC_MODE_RW_MASK);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // sticky event seen flags (status, write one to clear; set wins over clear)
  logic clr_evt;
  assign clr_evt = do_write && aw_addr_r == PTMC_OFS_STATUS && w_strb_r[0];

  always_ff @(posedge aclk) begin
    if (rst_all) begin
      fired_a_r <= '0;
      fired_b_r <= '0;
    end else begin
      fired_a_r <= (fired_a_r & ~(clr_evt ? w_data_r[NCH-1:0] : '0)) |
                   (cmp_match_a & ~gra_is_capture) | (capture_a & gra_is_capture);
      fired_b_r <= (fired_b_r & ~(clr_evt ? w_data_r[2*NCH-1:NCH] : '0)) | cmp_match_b;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // axi4-lite read channel
  logic [31:0] rd_mux;

  assign s_axi_arready = !s_axi_rvalid;

  always_comb begin
    rd_mux = '0;
    unique case (s_axi_araddr[7:0])
      PTMC_OFS_TRIG_SEL: rd_mux[7:0] = group_trigger_select_r;
      PTMC_OFS_MODE: rd_mux[7:0] = group_overlap_mode_r;
      PTMC_OFS_STATUS: rd_mux[2*NCH-1:0] = {fired_b_r, fired_a_r};
      default: rd_mux = '0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= PTMC_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_mux;
      s_axi_rresp <= (s_axi_araddr[7:0] == PTMC_OFS_TRIG_SEL || s_axi_araddr[7:0] == PTMC_OFS_MODE ||
                      s_axi_araddr[7:0] == PTMC_OFS_STATUS) ? PTMC_RESP_OKAY : PTMC_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // per-channel events and per-group load strobes
  genvar gi;
  generate
    for (gi = 0; gi < NCH; gi++) begin : g_ch
      // with register A capturing, the capture pulse takes the place of match A
      assign evt[gi].match_a = gra_is_capture[gi] ? capture_a[gi] : cmp_match_a[gi];
      assign evt[gi].match_b = cmp_match_b[gi];
    end
    for (gi = 0; gi < PTMC_NUM_PIN_GRP; gi++) begin : g_grp
      ptmc_group #(
        .NCH(NCH),
        .GW(PTMC_GRP_W)
      ) u_grp (
        .sel(group_trigger_select_r[gi*PTMC_SEL_W +: PTMC_SEL_W]),
        .nonoverlap(group_overlap_mode_r[gi]),
        .evt(evt),
        .next_val(next_value_latch[gi*PTMC_GRP_W +: PTMC_GRP_W]),
        .enable(next_enable[gi*PTMC_GRP_W +: PTMC_GRP_W]),
        .load(grp_load[gi])
      );
      // strobes are combinational from the pulse so the latch loads in the event cycle
      assign port_latch_load[gi*PTMC_GRP_W +: PTMC_GRP_W] = grp_load[gi].load;
      assign port_latch_data[gi*PTMC_GRP_W +: PTMC_GRP_W] = grp_load[gi].data;
    end
  endgenerate

  // group 3 has no pins; its field only steers the second next-value register layout
  assign grp3_trigger_sel = group_trigger_select_r[7:6];

endmodule

/* tb/ptmc_timer_model.sv */
// stand-in for the companion timer channels
`timescale 1ns/1ps
module ptmc_timer_model #(
  parameter int MARGIN = 3
) (
  input wire logic aclk,
  input wire logic go,
  input wire logic [1:0] ch,
  input wire logic [3:0] cap_mode,
  output logic [3:0] match_a,
  output logic [3:0] match_b,
  output logic [3:0] capture
);
  int cnt = 0;
  logic [1:0] c = 2'h0;
  logic fire_a;
  always @(posedge aclk) begin
    if (go) begin
      cnt <= MARGIN + 1;
      c <= ch;
    end else if (cnt != 0) begin
      cnt <= cnt - 1;
    end
  end
  assign match_b = (cnt == MARGIN + 1) ? 4'h1 << c : 4'h0;
  // a lands a margin after b, so zeros always lead ones
  assign fire_a = (cnt == 1);
  assign match_a = (fire_a && !cap_mode[c]) ? 4'h1 << c : 4'h0;
  assign capture = (fire_a && cap_mode[c]) ? 4'h1 << c : 4'h0;
endmodule

/* tb/ptmc_top_assertions.sv */
// checker: strobe and bus properties at the top ports
`timescale 1ns/1ps
module ptmc_top_assertions
  import ptmc_pkg::*;
#(
  parameter int NCH = PTMC_NUM_CH
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic hw_standby,
  input wire logic [NCH-1:0] cmp_match_a,
  input wire logic [NCH-1:0] cmp_match_b,
  input wire logic [NCH-1:0] capture_a,
  input wire logic [NCH-1:0] gra_is_capture,
  input wire logic [11:0] next_value_latch,
  input wire logic [11:0] next_enable,
  input wire logic [11:0] port_latch_load,
  input wire logic [1:0] grp3_trigger_sel,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  wire logic [NCH-1:0] eff_a = (cmp_match_a & ~gra_is_capture) | (capture_a & gra_is_capture);
  ////////////////////////////////////////////////////////////////////////////
  a_load_enabled: assert property ((port_latch_load & ~next_enable) == 12'h000)
    else $error("load on disabled bit");
  a_no_trig_load: assert property (eff_a == '0 && cmp_match_b == '0 |-> port_latch_load == 12'h000)
    else $error("load without event");
  a_b_zero_only: assert property ((cmp_match_a | capture_a) == '0 |-> (port_latch_load & next_value_latch) == 12'h000)
    else $error("one bit loaded at b");
  a_grp3_standby: assert property (hw_standby |=> grp3_trigger_sel == 2'h3)
    else $error("standby kept select");
  a_grp3_held: assert property (hw_standby [*2] |-> grp3_trigger_sel == 2'h3)
    else $error("select left standby value");
  a_grp3_kept: assert property ($changed(grp3_trigger_sel) |-> $rose(s_axi_bvalid) || $past(hw_standby) || !$past(aresetn))
    else $error("select changed alone");
  a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("bvalid dropped early");
  a_bvalid_drop: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("bvalid stuck");
  c_b_load: cover property (|cmp_match_b && |port_latch_load);
  c_cap_load: cover property (|capture_a && |port_latch_load);
  c_write: cover property ($rose(s_axi_bvalid));
endmodule

/* tb/test_pattern_trigger_mode_control.sv */
// bench: registers, trigger routing, overlap modes, capture, standby
`timescale 1ns/1ps
module test_pattern_trigger_mode_control;
  import ptmc_pkg::*;
  logic aclk = 0, aresetn = 0, hw_standby = 0, go = 0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] ch = 2'h0, bresp, rresp, g3, rsp, wrsp;
  logic [3:0] cap = 4'h0, ma, mb, ca;
  logic [11:0] nv = 12'h000, en = 12'h000, ld, la, lb, pd;
  logic [31:0] awaddr = 32'h0000_0000, wdata = 32'h0000_0000, araddr = 32'h0000_0000, rdata, rdv;
  int miscompares = 0, cmp_count = 0, cyc = 0;
  always #20 aclk = ~aclk;
  ptmc_top dut_u (.aclk(aclk), .aresetn(aresetn), .hw_standby(hw_standby), .cmp_match_a(ma), .cmp_match_b(mb),
    .capture_a(ca), .gra_is_capture(cap), .next_value_latch(nv), .next_enable(en), .port_latch_load(ld),
    .port_latch_data(pd), .grp3_trigger_sel(g3), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  ptmc_timer_model tmr_u (.aclk(aclk), .go(go), .ch(ch), .cap_mode(cap), .match_a(ma), .match_b(mb), .capture(ca));
  // strobes are one cycle wide, so collect them per event kind
  always @(posedge aclk) begin
    if (|mb) lb = lb | ld;
    else la = la | ld;
    cyc++;
    if (cyc == 4000) begin
      miscompares++;
      wrap_up();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [11:0] e, input logic [11:0] g);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic wrap_up;
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic done;
    done = 1'b0;
    awaddr <= {24'h00_0000, a};
    wdata <= {24'h00_0000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        wrsp = bresp;
        bready <= 1'b0;
        done = 1'b1;
      end
    end
    // one idle edge so a following call never re-raises bready in the same step
    @(posedge aclk);
  endtask
  task automatic rd(input logic [7:0] a);
    logic done;
    done = 1'b0;
    araddr <= {24'h00_0000, a};
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        rdv = rdata;
        rsp = rresp;
        rready <= 1'b0;
        done = 1'b1;
      end
    end
    @(posedge aclk);
  endtask
  task automatic fire(input logic [1:0] c);
    la = 12'h000;
    lb = 12'h000;
    ch <= c;
    go <= 1;
    @(posedge aclk);
    go <= 0;
    repeat (8) @(posedge aclk);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rd(PTMC_OFS_TRIG_SEL);
    chk("tsel", 12'h0ff, rdv[11:0]);
    rd(PTMC_OFS_MODE);
    chk("mode", 12'h0f0, rdv[11:0]);
    chk("g3", 12'h003, 12'(g3));
  endtask
  task automatic t_mode;
    wr(PTMC_OFS_MODE, 8'h00);
    chk("wresp", 12'(PTMC_RESP_OKAY), 12'(wrsp));
    rd(PTMC_OFS_MODE);
    chk("mode ro", 12'h0f0, rdv[11:0]);
    wr(PTMC_OFS_MODE, 8'h08);
    rd(PTMC_OFS_MODE);
    chk("mode spare", 12'h0f8, rdv[11:0]);
  endtask
  task automatic t_route;
    wr(PTMC_OFS_TRIG_SEL, 8'he4);
    nv <= 12'h5a3;
    en <= 12'hf7e;
    chk("g3", 12'h003, 12'(g3));
    for (int c = 0; c < 4; c++) begin
      fire(2'(c));
      chk("load a", 12'hf7e & (12'h00f << (4 * c)), la);
      chk("load b", 12'h000, lb);
    end
    // every channel has shown both events by now
    rd(PTMC_OFS_STATUS);
    chk("status", 12'h0ff, rdv[11:0]);
    wr(PTMC_OFS_STATUS, 8'h0f);
    rd(PTMC_OFS_STATUS);
    chk("status clr", 12'h0f0, rdv[11:0]);
    wr(PTMC_OFS_TRIG_SEL, 8'h1b);
    chk("g3", 12'h000, 12'(g3));
  endtask
  task automatic t_nov;
    wr(PTMC_OFS_TRIG_SEL, 8'h00);
    wr(PTMC_OFS_MODE, 8'h05);
    nv <= 12'h3c5;
    fire(2'h0);
    chk("nov a", 12'hf7e, la);
    chk("nov b", 12'hc0a, lb);
    chk("data", 12'h3c5, pd);
  endtask
  task automatic t_cap;
    wr(PTMC_OFS_MODE, 8'h00);
    cap <= 4'h1;
    fire(2'h0);
    chk("cap a", 12'hf7e, la);
    chk("cap b", 12'h000, lb);
    cap <= 4'h0;
  endtask
  task automatic t_stby;
    wr(PTMC_OFS_MODE, 8'h0f);
    hw_standby <= 1;
    repeat (2) @(posedge aclk);
    hw_standby <= 0;
    rd(PTMC_OFS_TRIG_SEL);
    chk("stby tsel", 12'h0ff, rdv[11:0]);
    rd(PTMC_OFS_MODE);
    chk("stby mode", 12'h0f0, rdv[11:0]);
    rd(PTMC_OFS_STATUS);
    chk("stby status", 12'h000, rdv[11:0]);
    rd(8'h10);
    chk("unmapped", 12'h000, rdv[11:0]);
    chk("resp", 12'(PTMC_RESP_SLVERR), 12'(rsp));
    wr(8'h10, 8'h55);
    chk("wresp bad", 12'(PTMC_RESP_SLVERR), 12'(wrsp));
  endtask
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    t_reset();
    t_mode();
    t_route();
    t_nov();
    t_cap();
    t_stby();
    wrap_up();
  end
endmodule
bind ptmc_top ptmc_top_assertions #(.NCH(NCH)) chk_u (.aclk(aclk), .aresetn(aresetn), .hw_standby(hw_standby),
  .cmp_match_a(cmp_match_a), .cmp_match_b(cmp_match_b), .capture_a(capture_a), .gra_is_capture(gra_is_capture),
  .next_value_latch(next_value_latch), .next_enable(next_enable), .port_latch_load(port_latch_load),
  .grp3_trigger_sel(grp3_trigger_sel), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready));
